// file: common/sps_pkg.sv
// Package: constants, types and register map of the status pin and strap block
package sps_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int NUM_PINS   = 4;    // Multipurpose status pins
   localparam int NUM_IND    = 6;    // Indications selectable per pin
   localparam int WORD_W     = 16;   // Startup tuning word width
   localparam int ROM_DEPTH  = 8;    // Tuning words held in the ROM
   localparam int NUM_EVT    = 5;    // Interrupt event bits

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS       = 10;  // Period of ref_clk
   localparam int STRAP_NS     = 10;  // Length of the power-up input window
   localparam int STRAP_CYC_RAW = (STRAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STRAP_CYC    = (STRAP_CYC_RAW < 1) ? 1 : STRAP_CYC_RAW;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_PIN_SEL  = 8'h00;  // Per-pin selection bytes
   localparam logic [7:0] OFS_STRAP    = 8'h04;  // Latched strap and clock mode
   localparam logic [7:0] OFS_TUNE     = 8'h08;  // Startup tuning word register
   localparam logic [7:0] OFS_FLAGS    = 8'h0C;  // Live internal status flags
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;  // Sticky events, write one to clear
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;  // Event enables
   localparam logic [7:0] OFS_CTRL     = 8'h18;  // Loop control

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int SEL_LOR      = 0;   // Reference-loss select bit
   localparam int SEL_OOL      = 1;   // Out-of-limits select bit
   localparam int SEL_REF      = 6;   // 0 first reference, 1 second
   localparam int EVT_STRAP    = 0;   // Strap latched event
   localparam int EVT_FLAG0    = 1;   // First of four flag-change events
   localparam int STRAP_DIRECT = 3;   // Strap bit choosing the clock source
   localparam logic [31:0] RST_PIN_SEL  = 32'h0000_0000;
   localparam logic [15:0] RST_TUNE     = 16'h0000;
   localparam logic [4:0]  RST_MASK     = 5'h00;
   localparam logic [5:0]  MULT_XTAL    = 6'h28;   // Multiplier in crystal mode
   localparam logic [5:0]  MULT_DIRECT  = 6'h01;   // Multiplier bypassed
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // Internal status indications feeding the pins
   typedef struct packed {
      logic [3:0] aux;   // Four general status flags
      logic [1:0] out_of_limits_flag;   // Out-of-limits flag per reference
      logic [1:0] reference_loss_flag;   // Reference-loss flag per reference
   } sps_flags_t;

   // Start-up configuration taken from the straps
   typedef struct packed {
      logic [15:0] tune;    // Startup tuning word
      logic [5:0]  mult;    // System clock multiplier factor
      logic        direct;  // 1 direct clock, 0 crystal/multiplier
   } sps_cfg_t;

   // Strap sequencer, one bit changes per step except RUN back to SAMPLE
   typedef enum logic [1:0] {
      SPS_SAMPLE = 2'b00,   // Pins are inputs
      SPS_LATCH  = 2'b01,   // Falling edge of the window
      SPS_RUN    = 2'b11    // Normal output function
   } sps_state_t;

endpackage

// file: rtl/sps_rom.sv
// Startup tuning word ROM, eight words addressed by the lower three straps
`timescale 1ns/100ps
`default_nettype none
module sps_rom #(
   parameter int WIDTH = sps_pkg::WORD_W,
   parameter int DEPTH = sps_pkg::ROM_DEPTH
) (
   // Address and word
   input  wire logic [$clog2(DEPTH)-1:0] addr,
   output logic      [WIDTH-1:0]         word
);
   import sps_pkg::*;

   // ---------------------------------------------------------------
   // Contents: word = f_out * 2^16 / 1 GHz
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] rom_mem [DEPTH];  // Constant table

   // Table of start frequencies 0 .. 155.51758 MHz
   // Listed start frequencies
   always_comb begin
      rom_mem[0] = 16'h0000;   // 0 MHz
      rom_mem[1] = 16'h09F4;   // 38.87939 MHz
      rom_mem[2] = 16'h0D45;   // 51.83411 MHz
      rom_mem[3] = 16'h0FBA;   // 61.43188 MHz
      rom_mem[4] = 16'h13E8;   // 77.75879 MHz
      rom_mem[5] = 16'h1797;   // 92.14783 MHz
      rom_mem[6] = 16'h1F75;   // 122.87903 MHz
      rom_mem[7] = 16'h27D0;   // 155.51758 MHz
   end

   // Read port
   assign word = rom_mem[addr];
endmodule
`default_nettype wire

// file: rtl/sps_top.sv
// Status pin multiplexer, strap latch and AXI4-Lite register file
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Each pin ORs its six selected indications
// - Reference flags come from one selected reference
// - Loss and limit both selected: either asserts
// - Pins are inputs during the reset window
// - Window end latches pins into strap register
// - Window end returns pins to output use
// - Manual reset repeats the same sampling sequence
// - Lower three straps pick one ROM word
// - ROM word loads tuning register without strobe
// - Fourth strap picks crystal or direct clock
// - Crystal mode starts with multiplier forty
// - Loop stays open until host closes it
// - ROM words give the listed start frequencies
module sps_top (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      manual_reset,
   // Internal status indications
   input  wire sps_pkg::sps_flags_t       flags,
   // Multipurpose status pins
   input  wire logic [3:0]                pin_in,
   output logic      [3:0]                pin_out,
   output logic      [3:0]                pin_oe_n,
   // Start-up configuration and loop control
   output sps_pkg::sps_cfg_t              cfg,
   output logic                           loop_closed,
   output logic                           irq,
   // AXI4-Lite slave
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic      [1:0]                s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic      [31:0]               s_axi_rdata,
   output logic      [1:0]                s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   import sps_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   sps_state_t   st_q, st_d;           // Strap sequencer
   logic [1:0]   win_q, win_d;         // Window cycle counter
   logic [3:0]   strap_q, strap_d;     // Latched strap levels
   sps_cfg_t     cfg_q, cfg_d;         // Clock mode and tuning word
   logic         loop_q, loop_d;       // Loop closed by host
   logic [3:0]   pin_q, pin_d;         // Registered pin drive
   logic [3:0]   oen_q, oen_d;         // Registered pin enables
   logic [31:0]  sel_q, sel_d;         // Selection bytes, one per pin
   logic [4:0]   stat_q, stat_d;       // Sticky events
   logic [4:0]   mask_q, mask_d;       // Event enables
   logic         irq_q, irq_d;         // Interrupt output
   logic [3:0]   prev_q;               // Previous reference flags
   logic [15:0]  rom_word;             // ROM output
   logic [4:0]   evt;                  // Event pulses
   // Bus state
   logic         aw_q, aw_d, w_q, w_d; // Address and data held
   logic [7:0]   awa_q, awa_d;         // Held write address
   logic [31:0]  wd_q, wd_d;           // Held write data
   logic [3:0]   ws_q, ws_d;           // Held strobes
   logic         bv_q, bv_d;           // Write response valid
   logic [1:0]   br_q, br_d;           // Write response code
   logic         rv_q, rv_d;           // Read data valid
   logic [31:0]  rd_q, rd_d;           // Read data
   logic [1:0]   rr_q, rr_d;           // Read response code
   logic         wr_go;                // Write performed this cycle
   logic [31:0]  wmask;                // Byte strobes widened

   // Selects the indication of one pin from its selection byte
   function automatic logic pin_level(input logic [7:0] s, input sps_flags_t f);
      logic [5:0] v;
      v = {f.aux, f.out_of_limits_flag[s[SEL_REF]], f.reference_loss_flag[s[SEL_REF]]};
      return |(s[5:0] & v);
   endfunction

   // Decodes a byte offset into a known register
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == OFS_PIN_SEL) || (a == OFS_STRAP) || (a == OFS_TUNE) ||
             (a == OFS_FLAGS) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
             (a == OFS_CTRL);
   endfunction

   // ---------------------------------------------------------------
   // Startup ROM
   // ---------------------------------------------------------------
   sps_rom #(.WIDTH(WORD_W), .DEPTH(ROM_DEPTH)) u_rom (
      .addr (strap_d[2:0]),
      .word (rom_word)
   );

   // ---------------------------------------------------------------
   // Strap sequencer
   // ---------------------------------------------------------------
   // Window opens at reset and while manual reset is held
   always_comb begin
      st_d    = st_q;
      win_d   = win_q;
      strap_d = strap_q;
      cfg_d   = cfg_q;
      unique case (st_q)
         SPS_SAMPLE: begin
            if (manual_reset) begin
               win_d = 2'(STRAP_CYC);
            end else if (win_q > 2'h1) begin
               win_d = win_q - 2'h1;
            end else begin
               win_d = 2'h0;
               st_d  = SPS_LATCH;
            end
         end
         SPS_LATCH: begin
            // Resistors give one of 16 patterns
            strap_d = pin_in;
            st_d    = SPS_RUN;
         end
         SPS_RUN: begin
            if (manual_reset) begin
               win_d = 2'(STRAP_CYC);
               st_d  = SPS_SAMPLE;
            end
         end
      endcase
      if (st_q == SPS_LATCH) begin
         cfg_d.tune   = rom_word;
         cfg_d.direct = pin_in[STRAP_DIRECT];
         cfg_d.mult   = pin_in[STRAP_DIRECT] ? MULT_DIRECT : MULT_XTAL;
      end else if (wr_go && awa_q == OFS_TUNE) begin
         cfg_d.tune = (cfg_q.tune & ~wmask[15:0]) | (wd_q[15:0] & wmask[15:0]);
      end
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q    <= SPS_SAMPLE;
         win_q   <= 2'(STRAP_CYC);
         strap_q <= 4'h0;
         cfg_q   <= '{tune: RST_TUNE, mult: MULT_XTAL, direct: 1'b0};
      end else begin
         st_q    <= st_d;
         win_q   <= win_d;
         strap_q <= strap_d;
         cfg_q   <= cfg_d;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Per-pin OR of selected flags
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_d[i] = pin_level(sel_q[8*i +: 8], flags);
         oen_d[i] = (st_d != SPS_RUN);
      end
   end

   // Pin registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_q <= 4'h0;
         oen_q <= 4'hF;
      end else begin
         pin_q <= pin_d;
         oen_q <= oen_d;
      end
   end

   // ---------------------------------------------------------------
   // Control, interrupt and selection registers
   // ---------------------------------------------------------------
   assign wr_go = aw_q && w_q && !bv_q;
   assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   assign evt   = {{flags.out_of_limits_flag, flags.reference_loss_flag} ^ prev_q, st_q == SPS_LATCH};

   // Register writes, events and interrupt level
   always_comb begin
      sel_d  = sel_q;
      mask_d = mask_q;
      loop_d = loop_q;
      stat_d = stat_q;
      if (wr_go) begin
         unique case (awa_q)
            OFS_PIN_SEL:  sel_d  = (sel_q & ~wmask) | (wd_q & wmask);
            OFS_IRQ_MASK: if (ws_q[0]) mask_d = wd_q[4:0];
            OFS_IRQ_STAT: if (ws_q[0]) stat_d = stat_q & ~wd_q[4:0];
            OFS_CTRL:     if (ws_q[0]) loop_d = wd_q[0];
            default:      ;
         endcase
      end
      // Events set after the clear so a same-cycle event survives
      stat_d = stat_d | evt;
      if (st_q != SPS_RUN) begin
         loop_d = 1'b0;
      end
      irq_d = |(stat_d & mask_d);
   end

   // Control registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_q  <= RST_PIN_SEL;
         mask_q <= RST_MASK;
         loop_q <= 1'b0;
         stat_q <= 5'h00;
         irq_q  <= 1'b0;
         prev_q <= 4'h0;
      end else begin
         sel_q  <= sel_d;
         mask_q <= mask_d;
         loop_q <= loop_d;
         stat_q <= stat_d;
         irq_q  <= irq_d;
         prev_q <= {flags.out_of_limits_flag, flags.reference_loss_flag};
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite channels
   // ---------------------------------------------------------------
   // Address and data taken in either order, answer after both
   always_comb begin
      aw_d = aw_q;  awa_d = awa_q;  w_d = w_q;  wd_d = wd_q;  ws_d = ws_q;
      bv_d = bv_q;  br_d = br_q;  rv_d = rv_q;  rd_d = rd_q;  rr_d = rr_q;
      if (s_axi_awvalid && !aw_q) begin
         aw_d  = 1'b1;
         awa_d = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_q) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         bv_d = 1'b1;
         br_d = is_mapped(awa_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
         aw_d = 1'b0;
         w_d  = 1'b0;
      end
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = is_mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
         unique case ({s_axi_araddr[7:2], 2'b00})
            OFS_PIN_SEL:  rd_d = sel_q;
            OFS_STRAP:    rd_d = {21'h0, cfg_q.mult, cfg_q.direct, strap_q};
            OFS_TUNE:     rd_d = {16'h0, cfg_q.tune};
            OFS_FLAGS:    rd_d = {24'h0, flags};
            OFS_IRQ_STAT: rd_d = {27'h0, stat_q};
            OFS_IRQ_MASK: rd_d = {27'h0, mask_q};
            OFS_CTRL:     rd_d = {31'h0, loop_q};
            default:      rd_d = 32'h0000_0000;
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   // Bus registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_q <= 1'b0;  awa_q <= 8'h00;  w_q <= 1'b0;  wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;  bv_q <= 1'b0;  br_q <= RESP_OKAY;  rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;  rr_q <= RESP_OKAY;
      end else begin
         aw_q <= aw_d;  awa_q <= awa_d;  w_q <= w_d;  wd_q <= wd_d;
         ws_q <= ws_d;  bv_q <= bv_d;  br_q <= br_d;  rv_q <= rv_d;
         rd_q <= rd_d;  rr_q <= rr_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign pin_out       = pin_q;
   assign pin_oe_n      = oen_q;
   assign cfg           = cfg_q;
   assign loop_closed   = loop_q;
   assign irq           = irq_q;
   assign s_axi_awready = !aw_q;
   assign s_axi_wready  = !w_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_pin_or_sel: assert property (@(posedge ref_clk) disable iff (rst)
      pin_out[0] == pin_level($past(sel_q[7:0]), $past(flags)))
      else $error("pin 0 level differs from its selected flags");
   a_ref_pick: assert property (@(posedge ref_clk) disable iff (rst)
      (sel_q[15:8] == 8'h43) |=> pin_out[1] == $past(flags.reference_loss_flag[1] || flags.out_of_limits_flag[1]))
      else $error("pin 1 did not follow second reference flags");
   a_lor_or_ool: assert property (@(posedge ref_clk) disable iff (rst)
      (sel_q[7:0] == 8'h03 && (flags.reference_loss_flag[0] || flags.out_of_limits_flag[0])) |=> pin_out[0])
      else $error("pin 0 missed loss or limit flag");
   a_pins_input: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == SPS_SAMPLE) |-> pin_oe_n == 4'hF)
      else $error("pins driven during the strap window");
   a_strap_take: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == SPS_LATCH) |=> strap_q == $past(pin_in))
      else $error("strap register missed pin levels");
   a_drive_back: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == SPS_LATCH) |=> pin_oe_n == 4'h0 && st_q == SPS_RUN)
      else $error("pins not driving after the latch");
   a_manual_seq: assert property (@(posedge ref_clk) disable iff (rst)
      (manual_reset && st_q == SPS_RUN) |=> st_q == SPS_SAMPLE ##[1:4] st_q == SPS_LATCH)
      else $error("manual reset did not repeat the sampling");
   a_rom_load: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == SPS_LATCH && pin_in[2:0] == 3'h7) |=> cfg.tune == 16'h27D0)
      else $error("tuning word not loaded from the table");
   a_clk_mode: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == SPS_LATCH) |=> cfg.direct == $past(pin_in[3])
                              && (cfg.direct || cfg.mult == MULT_XTAL))
      else $error("clock mode or multiplier wrong after latch");
   a_loop_open: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q != SPS_RUN) |=> !loop_closed)
      else $error("loop closed during startup");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
      irq == |($past(stat_d) & $past(mask_d)))
      else $error("interrupt level differs from masked status");
endmodule
`default_nettype wire

// file: bench/sps_board.sv
// Board model: strap resistors and pin readback on the four pins
`timescale 1ns/100ps
`default_nettype none
module sps_board (
   // Pin wires
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe_n,
   output logic      [3:0] pin_in,
   // Resistor pattern
   input  wire logic [3:0] strap
);
   // Released pin rests at its pull level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pin_oe_n[i] ? strap[i] : pin_out[i];
      end
   end
endmodule
`default_nettype wire

// file: bench/sps_top_tb.sv
// Testbench: strap start-up, pin selection, interrupt and register access
`timescale 1ns/100ps
`default_nettype none
module sps_top_tb;
   import sps_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        ref_clk = 1'h0, rst = 1'h1, manual_reset = 1'h0;
   sps_flags_t  flags = '0;
   logic [3:0]  pin_in, pin_out, pin_oe_n, strap = 4'h5, s_axi_wstrb = 4'hF;
   sps_cfg_t    cfg;
   logic        loop_closed, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
   int          miscompares = 0, n_compared = 0;
   logic [15:0] rom [8] = '{16'h0000, 16'h09F4, 16'h0D45, 16'h0FBA,
                            16'h13E8, 16'h1797, 16'h1F75, 16'h27D0};
   logic [7:0]  fl [6] = '{8'h00, 8'h02, 8'h08, 8'h05, 8'h10, 8'hFF};
   logic [3:0]  po [6] = '{4'h0, 4'h2, 4'h2, 4'h1, 4'h4, 4'h7};

   always #5 ref_clk = ~ref_clk;

   sps_top i_dut (.ref_clk, .rst, .manual_reset, .flags, .pin_in, .pin_out, .pin_oe_n, .cfg,
      .loop_closed, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   sps_board i_board (.pin_out, .pin_oe_n, .pin_in, .strap);

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ends the run when a wait ran out
   task automatic guard(input logic ok);
      if (!ok) begin
         miscompares++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int   n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      tb = 1'h0;
      n = 0;
      while (!tb && n < 50) begin
         @(negedge ref_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         wr_r = s_axi_bresp;
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         n++;
      end
      s_axi_bready <= 1'h0;
      guard(tb);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tb;
      int   n;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      tb = 1'h0;
      n = 0;
      while (!tb && n < 50) begin
         @(negedge ref_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge ref_clk);
         if (ta) s_axi_arvalid <= 1'h0;
         n++;
      end
      s_axi_rready <= 1'h0;
      guard(tb);
   endtask

   // Waits for the pins to turn to outputs, then checks the start-up set
   task automatic settle(input logic [3:0] s);
      int n;
      n = 0;
      while (pin_oe_n !== 4'h0 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      guard(n < 20);
      chk(pin_oe_n, 4'h0);
      chk(cfg, {rom[s[2:0]], (s[3] ? 6'h01 : 6'h28), s[3]});
      rd(OFS_STRAP, rd_d, rd_r);
      chk(rd_d, {21'h0, (s[3] ? 6'h01 : 6'h28), s[3], s});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      settle(4'h5);
      rd(OFS_IRQ_STAT, rd_d, rd_r);
      chk(rd_d[0], 1'h1);
      // Every strap pattern through a manual reset
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         strap <= i[3:0];
         manual_reset <= 1'h1;
         repeat (3) @(negedge ref_clk);
         chk(pin_oe_n, 4'hF);
         @(posedge ref_clk);
         manual_reset <= 1'h0;
         settle(i[3:0]);
      end
      chk(loop_closed, 1'h0);
      wr(OFS_CTRL, 32'h1);
      chk(wr_r, RESP_OKAY);
      repeat (2) @(negedge ref_clk);
      chk(loop_closed, 1'h1);
      // Pin 1 first reference, pin 2 second reference, pin 3 aux, pin 4 none
      wr(OFS_PIN_SEL, 32'h0004_4303);
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         flags <= fl[i];
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(pin_out, po[i]);
      end
      // Interrupt raise, mask and clear
      wr(OFS_IRQ_STAT, 32'h1F);
      wr(OFS_IRQ_MASK, 32'h06);
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'h0);
      @(posedge ref_clk);
      flags <= 8'h01;
      repeat (3) @(negedge ref_clk);
      chk(irq, 1'h1);
      rd(OFS_IRQ_STAT, rd_d, rd_r);
      chk(rd_d, 32'h1C);
      rd(OFS_FLAGS, rd_d, rd_r);
      chk(rd_d, 32'h01);
      chk(rd_r, RESP_OKAY);
      wr(OFS_IRQ_STAT, 32'h1E);
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'h0);
      // Unmapped offset
      rd(8'h1C, rd_d, rd_r);
      chk(rd_r, RESP_SLVERR);
      chk(rd_d, 32'h0);
      wr(8'h1C, 32'hFFFF_FFFF);
      chk(wr_r, RESP_SLVERR);
      wr(OFS_TUNE, 32'h0000_1234);
      chk(cfg.tune, 16'h1234);
      results();
   end
endmodule
`default_nettype wire
